// ### rtl/ssr_rate_cfg.sv
// secondary serial rate configuration register and rate qualifier
`timescale 1ns/1ns
`default_nettype none
module ssr_rate_cfg (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// register port
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// measured secondary rate
	input wire logic i_meas_valid,
	input wire logic [19:0] i_meas_rate,
	// configuration seen by the clocking logic
	output logic o_auto_mode,
	output logic o_tolerance_wide,
	// qualification result
	output logic o_result_valid,
	output logic o_rate_locked,
	output logic [5:0] o_rate_code,
	output logic [19:0] o_nominal_rate
);

	// =========================================================
	// reset release
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// =========================================================
	// configuration register
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic cfg_hit;
	logic [5:0] secondary_rate_code;
	logic secondary_rate_tolerance_sel;

	assign cfg_hit = (i_reg_addr == ssr_pkg::CFG_ADDR);
	assign secondary_rate_code = cfg_r[ssr_pkg::CODE_MSB:ssr_pkg::CODE_LSB];
	assign secondary_rate_tolerance_sel = cfg_r[ssr_pkg::TOL_BIT];

	always_comb begin
		cfg_nxt = i_reg_wdata;
		cfg_nxt[ssr_pkg::RSVD_BIT] = ssr_pkg::RSVD_VALUE;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= ssr_pkg::CFG_RESET;
		end else if (i_reg_wr && cfg_hit) begin
			cfg_r <= cfg_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_reg_rdata <= ssr_pkg::RDATA_UNMAPPED;
		end else if (cfg_hit) begin
			o_reg_rdata <= cfg_r;
		end else begin
			o_reg_rdata <= ssr_pkg::RDATA_UNMAPPED;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_auto_mode <= 1'b1;
			o_tolerance_wide <= 1'b0;
		end else begin
			o_auto_mode <= (secondary_rate_code == ssr_pkg::CODE_AUTO);
			o_tolerance_wide <= secondary_rate_tolerance_sel;
		end
	end

	// =========================================================
	// per-entry comparison against the rate table
	logic [ssr_pkg::NUM_CODES:1] in_range;
	logic [ssr_pkg::NUM_CODES:1] near_narrow;
	logic [ssr_pkg::NUM_CODES:1] near_wide;

	genvar g;
	generate
		for (g = 1; g <= ssr_pkg::NUM_CODES; g++) begin : g_entry
			localparam logic [59:0] ENTRY = ssr_pkg::rate_entry(6'(g));
			ssr_match u_match (
				.i_rate(i_meas_rate),
				.i_nom(ENTRY[59:40]),
				.i_min(ENTRY[39:20]),
				.i_max(ENTRY[19:0]),
				.o_in_range(in_range[g]),
				.o_near_narrow(near_narrow[g]),
				.o_near_wide(near_wide[g])
			);
		end
	endgenerate

	// =========================================================
	// mode decision
	logic hit_nxt;
	logic [5:0] code_nxt;
	logic [59:0] sel_entry;

	always_comb begin
		hit_nxt = 1'b0;
		code_nxt = ssr_pkg::CODE_AUTO;
		if (secondary_rate_code == ssr_pkg::CODE_AUTO) begin
			// highest rate first; only standard table rates qualify
			for (int k = ssr_pkg::NUM_CODES; k >= 1; k--) begin
				if (secondary_rate_tolerance_sel ? near_wide[k] : near_narrow[k]) begin
					hit_nxt = 1'b1;
					code_nxt = 6'(k);
				end
			end
		end else if (secondary_rate_code <= ssr_pkg::CODE_LAST) begin
			hit_nxt = in_range[secondary_rate_code];
			code_nxt = secondary_rate_code;
		end
	end

	assign sel_entry = ssr_pkg::rate_entry(code_nxt);

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_result_valid <= 1'b0;
		end else begin
			o_result_valid <= i_meas_valid;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rate_locked <= 1'b0;
			o_rate_code <= ssr_pkg::CODE_AUTO;
			o_nominal_rate <= 20'h0_0000;
		end else if (i_meas_valid) begin
			o_rate_locked <= hit_nxt;
			o_rate_code <= hit_nxt ? code_nxt : ssr_pkg::CODE_AUTO;
			o_nominal_rate <= hit_nxt ? sel_entry[59:40] : 20'h0_0000;
		end
	end

	// =========================================================
	// checks
	sequence s_cfg_write(logic [7:0] d);
		i_reg_wr && cfg_hit && (d == i_reg_wdata);
	endsequence

	sequence s_cfg_read;
		!i_reg_wr && cfg_hit;
	endsequence

	// table entry of the reported code, for the auto result check
	logic [59:0] locked_entry;

	assign locked_entry = ssr_pkg::rate_entry(o_rate_code);

	sequence s_meas(logic [5:0] c, logic [19:0] r);
		i_meas_valid && (secondary_rate_code == c) && (i_meas_rate == r);
	endsequence

	property p_write_readback;
		logic [7:0] d;
		@(posedge i_ref_clk) disable iff (!rst_n)
		(s_cfg_write(i_reg_wdata), d = i_reg_wdata) ##1 s_cfg_read
		|=> (o_reg_rdata == {d[7:1], 1'b0});
	endproperty
	a_write_readback: assert property (p_write_readback) else $error("readback mismatch");

	property p_unmapped_zero;
		@(posedge i_ref_clk) disable iff (!rst_n)
		!cfg_hit |=> (o_reg_rdata == 8'h00);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_rsvd_zero;
		@(posedge i_ref_clk) disable iff (!rst_n)
		i_reg_wr && cfg_hit |=> ##1 !o_reg_rdata[0];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read back set");

	property p_auto_48k;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_meas(6'h00, 20'd48000) |=> o_rate_locked && (o_rate_code == 6'h14) && o_result_valid;
	endproperty
	a_auto_48k: assert property (p_auto_48k) else $error("auto mode missed 48000");

	property p_code1;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_meas(6'h01, 20'd670320) |=> o_rate_locked && (o_nominal_rate == 20'd768000);
	endproperty
	a_code1: assert property (p_code1) else $error("code 1 range low edge");

	property p_code20_edges;
		@(posedge i_ref_clk) disable iff (!rst_n)
		(s_meas(6'h14, 20'd49440) |=> o_rate_locked) and
		(s_meas(6'h14, 20'd49441) |=> !o_rate_locked);
	endproperty
	a_code20_edges: assert property (p_code20_edges) else $error("code 20 range edge");

	property p_code33_edges;
		@(posedge i_ref_clk) disable iff (!rst_n)
		(s_meas(6'h21, 20'd6982) |=> o_rate_locked && (o_nominal_rate == 20'd8000)) and
		(s_meas(6'h21, 20'd6981) |=> !o_rate_locked);
	endproperty
	a_code33_edges: assert property (p_code33_edges) else $error("code 33 range edge");

	property p_tolerance;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_meas(6'h00, 20'd50400) |=> (o_rate_locked == $past(secondary_rate_tolerance_sel));
	endproperty
	a_tolerance: assert property (p_tolerance) else $error("tolerance select ignored");

	property p_standard_only;
		@(posedge i_ref_clk) disable iff (!rst_n)
		i_meas_valid && (secondary_rate_code == 6'h00) ##1 o_rate_locked
		|-> (o_nominal_rate == locked_entry[59:40]) && (o_rate_code != 6'h00);
	endproperty
	a_standard_only: assert property (p_standard_only) else $error("auto result not a table rate");

	property p_reserved_code;
		@(posedge i_ref_clk) disable iff (!rst_n)
		i_meas_valid && (secondary_rate_code > 6'h28) |=> !o_rate_locked;
	endproperty
	a_reserved_code: assert property (p_reserved_code) else $error("reserved code locked");

endmodule
`default_nettype wire

// ### rtl/ssr_pkg.sv
// constants and rate table for the secondary serial rate configuration block
package ssr_pkg;

	// =========================================================
	// register map
	localparam logic [7:0] CFG_ADDR = 8'h33;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 2;
	localparam int TOL_BIT = 1;
	localparam int RSVD_BIT = 0;
	localparam logic RSVD_VALUE = 1'b0;

	// =========================================================
	// codes and widths
	localparam int CODE_W = 6;
	localparam int RATE_W = 20;
	localparam int CALC_W = 28;
	localparam int NUM_CODES = 40;
	localparam logic [5:0] CODE_AUTO = 6'h00;
	localparam logic [5:0] CODE_LAST = 6'h28;

	// =========================================================
	// auto-detect tolerance, in percent
	localparam logic [27:0] PCT_SCALE = 28'h000_0064;
	localparam logic [27:0] TOL_NARROW_PCT = 28'h000_0001;
	localparam logic [27:0] TOL_WIDE_PCT = 28'h000_0005;

	// =========================================================
	// rate table: {nominal, lowest accepted, highest accepted} in Hz
	function automatic logic [59:0] rate_entry(input logic [5:0] code);
		case (code)
			6'h01: rate_entry = {20'd768000, 20'd670320, 20'd791040};
			6'h02: rate_entry = {20'd614400, 20'd536256, 20'd632832};
			6'h03: rate_entry = {20'd512000, 20'd446880, 20'd527360};
			6'h04: rate_entry = {20'd438857, 20'd383040, 20'd452022};
			6'h05: rate_entry = {20'd384000, 20'd335160, 20'd395520};
			6'h06: rate_entry = {20'd341333, 20'd297920, 20'd351573};
			6'h07: rate_entry = {20'd307200, 20'd268128, 20'd316416};
			6'h08: rate_entry = {20'd256000, 20'd223440, 20'd263680};
			6'h09: rate_entry = {20'd219429, 20'd191520, 20'd226011};
			6'h0a: rate_entry = {20'd192000, 20'd167580, 20'd197760};
			6'h0b: rate_entry = {20'd170667, 20'd148960, 20'd175786};
			6'h0c: rate_entry = {20'd153600, 20'd134064, 20'd158208};
			6'h0d: rate_entry = {20'd128000, 20'd111720, 20'd131840};
			6'h0e: rate_entry = {20'd109714, 20'd95760, 20'd113005};
			6'h0f: rate_entry = {20'd96000, 20'd83790, 20'd98880};
			6'h10: rate_entry = {20'd85333, 20'd74480, 20'd87893};
			6'h11: rate_entry = {20'd76800, 20'd67032, 20'd79104};
			6'h12: rate_entry = {20'd64000, 20'd55860, 20'd65920};
			6'h13: rate_entry = {20'd54857, 20'd47880, 20'd56502};
			6'h14: rate_entry = {20'd48000, 20'd41895, 20'd49440};
			6'h15: rate_entry = {20'd42667, 20'd37240, 20'd43946};
			6'h16: rate_entry = {20'd38400, 20'd33516, 20'd39552};
			6'h17: rate_entry = {20'd32000, 20'd27930, 20'd32960};
			6'h18: rate_entry = {20'd27429, 20'd23940, 20'd28251};
			6'h19: rate_entry = {20'd24000, 20'd10947, 20'd24720};
			6'h1a: rate_entry = {20'd21333, 20'd18620, 20'd21973};
			6'h1b: rate_entry = {20'd19200, 20'd16758, 20'd19776};
			6'h1c: rate_entry = {20'd16000, 20'd13965, 20'd16480};
			6'h1d: rate_entry = {20'd13714, 20'd11970, 20'd14125};
			6'h1e: rate_entry = {20'd12000, 20'd10473, 20'd12360};
			6'h1f: rate_entry = {20'd10667, 20'd9310, 20'd10986};
			6'h20: rate_entry = {20'd9600, 20'd8379, 20'd9888};
			6'h21: rate_entry = {20'd8000, 20'd6982, 20'd8240};
			6'h22: rate_entry = {20'd6857, 20'd5985, 20'd7062};
			6'h23: rate_entry = {20'd6000, 20'd5236, 20'd6180};
			6'h24: rate_entry = {20'd5333, 20'd4655, 20'd5493};
			6'h25: rate_entry = {20'd4800, 20'd4189, 20'd4944};
			6'h26: rate_entry = {20'd4000, 20'd3491, 20'd4120};
			6'h27: rate_entry = {20'd3429, 20'd2992, 20'd3531};
			6'h28: rate_entry = {20'd3000, 20'd2618, 20'd3090};
			default: rate_entry = 60'h000_0000_0000_0000;
		endcase
	endfunction

endpackage

// ### rtl/ssr_match.sv
// compares one measured rate against one rate table entry
`timescale 1ns/1ns
`default_nettype none
module ssr_match (
	// measured rate
	input wire logic [19:0] i_rate,
	// table entry
	input wire logic [19:0] i_nom,
	input wire logic [19:0] i_min,
	input wire logic [19:0] i_max,
	// results
	output logic o_in_range,
	output logic o_near_narrow,
	output logic o_near_wide
);
	logic [19:0] diff;
	logic [27:0] diff_scaled;
	logic [27:0] nom_ext;

	assign diff = (i_rate >= i_nom) ? (i_rate - i_nom) : (i_nom - i_rate);
	assign diff_scaled = 28'({8'h00, diff} * ssr_pkg::PCT_SCALE);
	assign nom_ext = {8'h00, i_nom};
	assign o_in_range = (i_rate >= i_min) && (i_rate <= i_max);
	assign o_near_narrow = diff_scaled <= 28'(nom_ext * ssr_pkg::TOL_NARROW_PCT);
	assign o_near_wide = diff_scaled <= 28'(nom_ext * ssr_pkg::TOL_WIDE_PCT);
endmodule
`default_nettype wire

// ### tb/ssr_rate_cfg_tb.sv
// self-checking bench for the secondary serial rate configuration block
`timescale 1ns/1ns
`default_nettype none
module ssr_rate_cfg_tb;
	// =========================================================
	// stimulus, observed outputs and model state
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_reg_wr = 1'b0;
	logic [7:0] i_reg_addr = 8'h33;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_meas_valid = 1'b0;
	logic [19:0] i_meas_rate = 20'h0_0000;
	logic [7:0] o_reg_rdata;
	logic o_auto_mode, o_tolerance_wide, o_result_valid, o_rate_locked;
	logic [5:0] o_rate_code;
	logic [19:0] o_nominal_rate;
	int failures = 0;
	int checks_done = 0;
	int seed = 32'h9d9d;
	int reg_m = 0;
	int exp_q[$];
	int tab_code[4] = '{1, 20, 33, 40};
	int tab_nom[4] = '{768000, 48000, 8000, 3000};
	int tab_lo[4] = '{670320, 41895, 6982, 2618};
	int tab_hi[4] = '{791040, 49440, 8240, 3090};
	int n, p, r;

	always #25 i_ref_clk = ~i_ref_clk;

	ssr_rate_cfg u_dut (
		.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_meas_valid(i_meas_valid), .i_meas_rate(i_meas_rate),
		.o_auto_mode(o_auto_mode), .o_tolerance_wide(o_tolerance_wide),
		.o_result_valid(o_result_valid), .o_rate_locked(o_rate_locked),
		.o_rate_code(o_rate_code), .o_nominal_rate(o_nominal_rate)
	);

	// =========================================================
	// model: index of the matching table entry, -1 when none
	function automatic int model_idx(input int rate);
		int code;
		int d;
		code = reg_m >> 2;
		for (int k = 0; k < 4; k++) begin
			d = rate - tab_nom[k];
			if (d < 0)
				d = -d;
			if (code == tab_code[k] && rate >= tab_lo[k] && rate <= tab_hi[k])
				return k;
			if (code == 0 && d * 100 <= tab_nom[k] * (reg_m[1] ? 5 : 1))
				return k;
		end
		return -1;
	endfunction

	// =========================================================
	// compare tasks
	task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected rdata exp %0h got %0h", exp, got);
		end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s exp %0b got %0b", what, exp, got);
		end
	endtask

	task automatic chk_res(input logic [26:0] exp);
		checks_done++;
		if ({o_rate_locked, o_rate_code, o_nominal_rate} !== exp) begin
			failures++;
			$display("unexpected result exp %0h got %0h", exp,
				{o_rate_locked, o_rate_code, o_nominal_rate});
		end
	endtask

	// =========================================================
	// register and measurement drivers
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge i_ref_clk);
		i_reg_wr = 1'b1;
		i_reg_addr = addr;
		i_reg_wdata = data;
		if (addr == 8'h33)
			reg_m = {data[7:1], 1'b0};
		@(negedge i_ref_clk);
		i_reg_wr = 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge i_ref_clk);
		i_reg_addr = addr;
		@(negedge i_ref_clk);
		chk_reg(exp, o_reg_rdata);
	endtask

	task automatic check_cfg();
		reg_read(8'h33, reg_m[7:0]);
		chk_flag("auto", (reg_m >> 2) == 0, o_auto_mode);
		chk_flag("tol", reg_m[1], o_tolerance_wide);
	endtask

	task automatic measure(input int rate);
		int k;
		@(negedge i_ref_clk);
		chk_flag("valid", 1'b0, o_result_valid);
		i_meas_valid = 1'b1;
		i_meas_rate = rate[19:0];
		exp_q.push_back(model_idx(rate));
		@(negedge i_ref_clk);
		i_meas_valid = 1'b0;
		k = exp_q.pop_front();
		chk_flag("valid", 1'b1, o_result_valid);
		if (k < 0)
			chk_res(27'h000_0000);
		else
			chk_res({1'b1, tab_code[k][5:0], tab_nom[k][19:0]});
	endtask

	task automatic do_reset();
		i_resetn = 1'b0;
		reg_m = 0;
		exp_q.delete();
		repeat (6) @(negedge i_ref_clk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_ref_clk);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// =========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		failures++;
		results();
	end

	// =========================================================
	// main sequence
	initial begin
		do_reset();
		check_cfg();
		chk_res(27'h000_0000);
		reg_write(8'h32, 8'hfc);
		check_cfg();
		reg_read(8'h32, 8'h00);
		$display("test reset and map done");
		for (int k = 0; k < 4; k++) begin
			reg_write(8'h33, {tab_code[k][5:0], 1'($random(seed)), 1'b1});
			check_cfg();
			r = $unsigned($random(seed)) % (tab_hi[k] - tab_lo[k] + 3);
			measure(tab_lo[k] - 1);
			measure(tab_lo[k]);
			measure(tab_hi[k]);
			measure(tab_hi[k] + 1);
			measure(tab_lo[k] - 1 + r);
		end
		$display("test fixed codes done");
		for (int t = 0; t < 2; t++) begin
			reg_write(8'h33, {6'h00, t[0], 1'b0});
			check_cfg();
			for (int k = 0; k < 4; k++) begin
				n = tab_nom[k];
				p = n / 100 * (t ? 5 : 1);
				measure(n);
				measure(n - p - 1);
				measure(n - p);
				measure(n + p);
				measure(n + p + 1);
				measure(n - n * 6 / 100 + $unsigned($random(seed)) % (n * 12 / 100 + 1));
			end
		end
		$display("test auto detect done");
		reg_write(8'h33, 8'ha4);
		check_cfg();
		measure(3000);
		reg_write(8'h33, 8'hff);
		check_cfg();
		measure(48000);
		$display("test reserved codes done");
		do_reset();
		check_cfg();
		chk_res(27'h000_0000);
		measure(8000);
		$display("test second reset done");
		results();
	end
endmodule
`default_nettype wire
